/* File: design/board_io_glue_consts.vh */
// Address map and field constants for the board peripheral I/O glue.
`ifndef BOARD_IO_GLUE_CONSTS_VH
`define BOARD_IO_GLUE_CONSTS_VH
`define IO_BASE_DEFAULT 16'h0000
`define CLOCK_SLOT_LO 16'h0000
`define CLOCK_SLOT_HI 16'h003F
`define CAN_SLOT_LO 16'h0040
`define CAN_SLOT_HI 16'h007F
`define DISPLAY_SLOT_LO 16'h0080
`define DISPLAY_SLOT_HI 16'h00BF
`define CLOCK_COUNTERS_LO 16'h0000
`define CLOCK_COUNTERS_HI 16'h000C
`define CLOCK_CONTROL_D 16'h000D
`define CLOCK_CONTROL_E 16'h000E
`define CLOCK_CONTROL_F 16'h000F
`define CAN_CONTROL 16'h0040
`define CAN_TX_LO 16'h004A
`define CAN_TX_HI 16'h0053
`define CAN_RX_LO 16'h0054
`define CAN_RX_HI 16'h005E
`define DISPLAY_CMD_PARAM_IN 16'h0080
`define DISPLAY_PARAM_OUT 16'h0081
`define ROUTE_IRQ0 2'h0
`define ROUTE_IRQ1 2'h1
`define ROUTE_TIMER0 2'h2
`define ROUTE_TIMER1 2'h3
`define CONTRAST_RESET 6'h00
`define SYNC_IDLE 45'h0000_0C1F_0000
`endif

/* File: design/board_peripheral_io_glue.v */
// Board glue: peripheral selects, register decode, signal routing, contrast, buzzer, keyboard and keypad.
//
// Behaviour
// - The clock-chip select is active for latched addresses from base plus 00h through base plus 3Fh.
// - Offsets 00h to 0Ch above the base decode to the clock chip's time and date counters, one per address.
// - Offsets 0Dh, 0Eh and 0Fh decode to the clock chip's control registers D, E and F.
// - The clock chip's periodic pulse is routed by a select input to interrupt 0, interrupt 1, timer 0 or timer 1.
// - The CAN select is active for offsets 40h through 7Fh above the base, and needs a data access only while the qualify input is set.
// - Offset 40h decodes to the CAN control register, 4Ah to 53h to transmit and 54h to 5Eh to receive buffer.
// - The display select is active for offsets 80h through BFh above the base.
// - Each rising edge of the contrast line advances a 6-bit step counter giving 64 levels.
// - The buzzer is on while its control line is low and off while it is high.
// - The keyboard clock is buffered to an interrupt input, and clock and data each have a two-way port line.
// - The 10 x 6 keypad state appears on two 8-bit ports and touch activity raises an interrupt line.
// - Selects decode from address only unless the qualify input adds the read and write strobes.
`timescale 1ns/1ps
`include "board_io_glue_consts.vh"
module board_peripheral_io_glue #(
  parameter [15:0] IO_BASE = `IO_BASE_DEFAULT
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire ale_i,
  input wire [7:0] ad_i,
  input wire [7:0] addr_hi_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire qualify_strobes_i,
  output reg clock_chip_select_n_o,
  output reg can_chip_select_n_o,
  output reg display_chip_select_n_o,
  output reg [5:0] periph_offset_o,
  output reg clock_counter_sel_o,
  output reg clock_control_d_sel_o,
  output reg clock_control_e_sel_o,
  output reg clock_control_f_sel_o,
  output reg can_control_sel_o,
  output reg can_tx_sel_o,
  output reg can_rx_sel_o,
  output reg display_cmd_param_in_sel_o,
  output reg display_param_out_sel_o,
  input wire clock_periodic_pulse_i,
  input wire [1:0] pulse_route_i,
  output reg ext_irq0_n_o,
  output reg ext_irq1_n_o,
  output reg timer0_count_in_o,
  output reg timer1_count_in_o,
  input wire contrast_ctl_i,
  output reg [5:0] contrast_level_o,
  input wire buzzer_ctl_i,
  output reg buzzer_on_o,
  input wire kbd_clk_i,
  output reg kbd_clk_o,
  output reg kbd_clk_oe_n_o,
  input wire kbd_data_i,
  output reg kbd_data_o,
  output reg kbd_data_oe_n_o,
  input wire mcu_kbd_clk_drive_i,
  input wire mcu_kbd_data_drive_i,
  output reg mcu_kbd_clk_o,
  output reg mcu_kbd_data_o,
  output reg kbd_irq_o,
  input wire [9:0] touch_rows_i,
  input wire [5:0] touch_cols_i,
  output reg [7:0] touch_port4_o,
  output reg [7:0] touch_port5_o,
  output reg touch_irq_o
);
  localparam NSYNC = 45;
  // Every pin input passes two flip-flops; only stage two is read.
  // Both stages reset to each pin's idle level, so no false strobe, buzzer pulse or keyboard edge follows reset.
  localparam [NSYNC-1:0] SYNC_RESET = `SYNC_IDLE;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  assign pin_raw = {ale_i, ad_i, addr_hi_i, rd_n_i, wr_n_i, qualify_strobes_i, clock_periodic_pulse_i,
                    pulse_route_i, contrast_ctl_i, buzzer_ctl_i, kbd_clk_i, kbd_data_i, mcu_kbd_clk_drive_i,
                    mcu_kbd_data_drive_i, touch_rows_i, touch_cols_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1_q[gi] <= SYNC_RESET[gi];
          sync2_q[gi] <= SYNC_RESET[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire s_ale = sync2_q[44];
  wire [7:0] s_ad = sync2_q[43:36];
  wire [7:0] s_hi = sync2_q[35:28];
  wire s_rd_n = sync2_q[27];
  wire s_wr_n = sync2_q[26];
  wire s_qual = sync2_q[25];
  wire s_pulse = sync2_q[24];
  wire [1:0] s_route = sync2_q[23:22];
  wire s_contrast = sync2_q[21];
  wire s_buzz = sync2_q[20];
  wire s_kclk = sync2_q[19];
  wire s_kdat = sync2_q[18];
  wire s_mclk = sync2_q[17];
  wire s_mdat = sync2_q[16];
  wire [9:0] s_rows = sync2_q[15:6];
  wire [5:0] s_cols = sync2_q[5:0];

  // The low address byte is latched on the falling edge of the address latch enable.
  reg ale_q;
  reg [7:0] addr_lo_q;
  reg contrast_q;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ale_q <= 1'b0;
      addr_lo_q <= 8'h00;
      contrast_q <= 1'b0;
    end else begin
      ale_q <= s_ale;
      contrast_q <= s_contrast;
      if (ale_q && !s_ale) begin
        addr_lo_q <= s_ad;
      end
    end
  end

  wire [15:0] addr = {s_hi, addr_lo_q};
  wire [15:0] off = addr - IO_BASE;
  wire strobe_ok = !s_qual || !s_rd_n || !s_wr_n;
  wire in_clock = (off <= `CLOCK_SLOT_HI);
  wire in_can = (off >= `CAN_SLOT_LO) && (off <= `CAN_SLOT_HI);
  wire in_disp = (off >= `DISPLAY_SLOT_LO) && (off <= `DISPLAY_SLOT_HI);

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_chip_select_n_o <= 1'b1;
      can_chip_select_n_o <= 1'b1;
      display_chip_select_n_o <= 1'b1;
      periph_offset_o <= 6'h00;
      clock_counter_sel_o <= 1'b0;
      clock_control_d_sel_o <= 1'b0;
      clock_control_e_sel_o <= 1'b0;
      clock_control_f_sel_o <= 1'b0;
      can_control_sel_o <= 1'b0;
      can_tx_sel_o <= 1'b0;
      can_rx_sel_o <= 1'b0;
      display_cmd_param_in_sel_o <= 1'b0;
      display_param_out_sel_o <= 1'b0;
    end else begin
      clock_chip_select_n_o <= !(in_clock && strobe_ok);
      can_chip_select_n_o <= !(in_can && strobe_ok);
      display_chip_select_n_o <= !(in_disp && strobe_ok);
      periph_offset_o <= off[5:0];
      clock_counter_sel_o <= (off <= `CLOCK_COUNTERS_HI);
      clock_control_d_sel_o <= (off == `CLOCK_CONTROL_D);
      clock_control_e_sel_o <= (off == `CLOCK_CONTROL_E);
      clock_control_f_sel_o <= (off == `CLOCK_CONTROL_F);
      can_control_sel_o <= (off == `CAN_CONTROL);
      can_tx_sel_o <= (off >= `CAN_TX_LO) && (off <= `CAN_TX_HI);
      can_rx_sel_o <= (off >= `CAN_RX_LO) && (off <= `CAN_RX_HI);
      // The master writes commands and parameters at 80h, and reads parameters out at 81h.
      display_cmd_param_in_sel_o <= (off == `DISPLAY_CMD_PARAM_IN);
      display_param_out_sel_o <= (off == `DISPLAY_PARAM_OUT);
    end
  end

  // Periodic pulse routing; unrouted interrupt lines idle high, unrouted timer inputs idle low.
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_irq0_n_o <= 1'b1;
      ext_irq1_n_o <= 1'b1;
      timer0_count_in_o <= 1'b0;
      timer1_count_in_o <= 1'b0;
    end else begin
      ext_irq0_n_o <= (s_route == `ROUTE_IRQ0) ? s_pulse : 1'b1;
      ext_irq1_n_o <= (s_route == `ROUTE_IRQ1) ? s_pulse : 1'b1;
      timer0_count_in_o <= (s_route == `ROUTE_TIMER0) ? s_pulse : 1'b0;
      timer1_count_in_o <= (s_route == `ROUTE_TIMER1) ? s_pulse : 1'b0;
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      contrast_level_o <= `CONTRAST_RESET;
      buzzer_on_o <= 1'b0;
    end else begin
      if (s_contrast && !contrast_q) begin
        contrast_level_o <= contrast_level_o + 6'h01;
      end
      buzzer_on_o <= !s_buzz;
    end
  end

  // Keyboard lines are open drain: the pin is pulled low only while the port drives low.
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kbd_clk_o <= 1'b0;
      kbd_clk_oe_n_o <= 1'b1;
      kbd_data_o <= 1'b0;
      kbd_data_oe_n_o <= 1'b1;
      mcu_kbd_clk_o <= 1'b1;
      mcu_kbd_data_o <= 1'b1;
      kbd_irq_o <= 1'b1;
    end else begin
      kbd_clk_o <= 1'b0;
      kbd_clk_oe_n_o <= s_mclk;
      kbd_data_o <= 1'b0;
      kbd_data_oe_n_o <= s_mdat;
      mcu_kbd_clk_o <= s_kclk;
      mcu_kbd_data_o <= s_kdat;
      kbd_irq_o <= s_kclk;
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      touch_port4_o <= 8'h00;
      touch_port5_o <= 8'h00;
      touch_irq_o <= 1'b0;
    end else begin
      touch_port4_o <= s_rows[7:0];
      touch_port5_o <= {s_cols, s_rows[9:8]};
      touch_irq_o <= |s_rows;
    end
  end
endmodule

/* File: bench/glue_monitor.sv */
// Concurrent checks on the ports of the board peripheral I/O glue.
`timescale 1ns/1ps
`include "board_io_glue_consts.vh"
module glue_monitor (
  input logic sys_clk_i, arst_n_i, qualify_strobes_i, rd_n_i, wr_n_i, buzzer_ctl_i, buzzer_on_o,
  input logic contrast_ctl_i, clock_periodic_pulse_i, ext_irq0_n_o, timer0_count_in_o, can_tx_sel_o, touch_irq_o,
  input logic clock_chip_select_n_o, can_chip_select_n_o, display_chip_select_n_o,
  input logic [1:0] pulse_route_i,
  input logic [5:0] contrast_level_o, periph_offset_o, touch_cols_i,
  input logic [9:0] touch_rows_i,
  input logic [7:0] touch_port4_o, touch_port5_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  buzzer_level_a: assert property ($stable(buzzer_ctl_i)[*4] |-> buzzer_on_o == !buzzer_ctl_i)
    else $error("buzzer level wrong");
  touch_map_a: assert property ($stable({touch_cols_i, touch_rows_i})[*4] |->
    {touch_port5_o, touch_port4_o, touch_irq_o} == {touch_cols_i, touch_rows_i, |touch_rows_i}) else $error("touch ports wrong");
  contrast_step_a: assert property ($changed(contrast_level_o) |-> contrast_level_o == $past(contrast_level_o) + 6'h01)
    else $error("contrast step wrong");
  contrast_rise_a: assert property ($rose(contrast_ctl_i) |-> ##[2:4] $changed(contrast_level_o))
    else $error("contrast edge missed");
  route_irq_a: assert property ($stable({clock_periodic_pulse_i, pulse_route_i})[*4] |->
    ext_irq0_n_o == (pulse_route_i == `ROUTE_IRQ0 ? clock_periodic_pulse_i : 1'b1)) else $error("irq route wrong");
  route_timer_a: assert property ($stable({clock_periodic_pulse_i, pulse_route_i})[*4] |->
    timer0_count_in_o == (pulse_route_i == `ROUTE_TIMER0 && clock_periodic_pulse_i)) else $error("timer route wrong");
  qualify_idle_a: assert property ((qualify_strobes_i && rd_n_i && wr_n_i)[*4] |->
    &{clock_chip_select_n_o, can_chip_select_n_o, display_chip_select_n_o}) else $error("select without strobe");
  select_onehot_a: assert property ($onehot0({~clock_chip_select_n_o, ~can_chip_select_n_o, ~display_chip_select_n_o}))
    else $error("two selects active");
  can_tx_a: assert property (can_tx_sel_o |-> periph_offset_o >= 6'h0A && periph_offset_o <= 6'h13)
    else $error("transmit flag off range");
  cover property ($rose(contrast_ctl_i));
  cover property (!can_chip_select_n_o);
  cover property (!display_chip_select_n_o && !rd_n_i);
endmodule
bind board_peripheral_io_glue glue_monitor glue_monitor_i (.*);

/* File: bench/mcu_bus_model.sv */
// Model of the microcontroller's multiplexed external data bus.
`timescale 1ns/1ps
module mcu_bus_model (
  input logic sys_clk_i,
  output logic ale_i, rd_n_i, wr_n_i,
  output logic [7:0] ad_i, addr_hi_i
);
  initial begin
    {ale_i, rd_n_i, wr_n_i, ad_i, addr_hi_i} = {3'b011, 16'h0000};
  end
  // The low byte is held well past the latch point before the bus turns to data.
  task automatic xfer(input logic [15:0] a, input logic wr);
    @(negedge sys_clk_i);
    {addr_hi_i, ad_i, ale_i} = {a, 1'b1};
    repeat (2) @(negedge sys_clk_i);
    ale_i = 0;
    repeat (4) @(negedge sys_clk_i);
    ad_i = ~a[7:0];
    {rd_n_i, wr_n_i} = wr ? 2'b10 : 2'b01;
    repeat (5) @(negedge sys_clk_i);
  endtask
  task automatic idle();
    @(negedge sys_clk_i);
    {rd_n_i, wr_n_i} = 2'b11;
  endtask
endmodule

/* File: bench/tb_board_peripheral_io_glue.sv */
// Self-checking bench for the board peripheral I/O glue.
`timescale 1ns/1ps
module tb_board_peripheral_io_glue;
  localparam logic [15:0] BASE = 16'h0300;
  logic sys_clk_i = 0, arst_n_i = 0, qualify_strobes_i = 0, clock_periodic_pulse_i = 0, contrast_ctl_i = 0;
  logic buzzer_ctl_i = 1, mcu_kbd_clk_drive_i = 1, mcu_kbd_data_drive_i = 1, kb_clk = 1, kb_data = 1;
  logic [1:0] pulse_route_i = 0;
  logic [9:0] touch_rows_i = 0;
  logic [5:0] touch_cols_i = 0, periph_offset_o, contrast_level_o;
  logic [7:0] ad_i, addr_hi_i, touch_port4_o, touch_port5_o;
  logic ale_i, rd_n_i, wr_n_i, clock_chip_select_n_o, can_chip_select_n_o, display_chip_select_n_o, clock_counter_sel_o;
  logic clock_control_d_sel_o, clock_control_e_sel_o, clock_control_f_sel_o, can_control_sel_o, can_tx_sel_o;
  logic can_rx_sel_o, display_cmd_param_in_sel_o, display_param_out_sel_o, ext_irq0_n_o, ext_irq1_n_o, buzzer_on_o;
  logic timer0_count_in_o, timer1_count_in_o, kbd_clk_i, kbd_clk_o, kbd_clk_oe_n_o, kbd_data_i, kbd_data_o;
  logic kbd_data_oe_n_o, mcu_kbd_clk_o, mcu_kbd_data_o, kbd_irq_o, touch_irq_o;
  int n_errors = 0, n_compared = 0;
  logic [15:0] offs [17] = '{16'h0000, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h003F, 16'h0040, 16'h004A,
    16'h0053, 16'h0054, 16'h005E, 16'h007F, 16'h0080, 16'h0081, 16'h00BF, 16'h00C0, 16'hFFFF};
  logic [15:0] o;
  board_peripheral_io_glue #(.IO_BASE(BASE)) board_peripheral_io_glue_i (.*);
  mcu_bus_model mcu_bus_model_i (.*);
  always #12.5 sys_clk_i = ~sys_clk_i;
  // Open-drain keyboard lines: low when the glue enables its driver, else the keyboard's level.
  assign kbd_clk_i = kbd_clk_oe_n_o ? kb_clk : kbd_clk_o;
  assign kbd_data_i = kbd_data_oe_n_o ? kb_data : kbd_data_o;
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bump(input int n);
    repeat (n) begin
      contrast_ctl_i = 1;
      w(2);
      contrast_ctl_i = 0;
      w(2);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #150000;
    n_errors++;
    end_sim();
  end
  initial begin
    w(2);
    arst_n_i = 1;
    foreach (offs[k]) begin
      o = offs[k];
      mcu_bus_model_i.xfer(BASE + o, k[0]);
      chk({display_chip_select_n_o, can_chip_select_n_o, clock_chip_select_n_o, periph_offset_o},
        {o > 16'h00BF || o < 16'h0080, o > 16'h007F || o < 16'h0040, o > 16'h003F, o[5:0]});
      chk({clock_counter_sel_o, clock_control_d_sel_o, clock_control_e_sel_o, clock_control_f_sel_o,
        can_control_sel_o, can_tx_sel_o, can_rx_sel_o, display_cmd_param_in_sel_o, display_param_out_sel_o},
        {o <= 16'h000C, o == 16'h000D, o == 16'h000E, o == 16'h000F, o == 16'h0040, o >= 16'h004A && o <= 16'h0053,
        o >= 16'h0054 && o <= 16'h005E, o == 16'h0080, o == 16'h0081});
      mcu_bus_model_i.idle();
    end
    qualify_strobes_i = 1;
    w(5);
    chk(display_chip_select_n_o, 1);
    mcu_bus_model_i.xfer(BASE + 16'h0081, 1);
    chk({display_chip_select_n_o, display_param_out_sel_o}, 2'b01);
    mcu_bus_model_i.idle();
    w(4);
    chk({display_chip_select_n_o, display_param_out_sel_o}, 2'b11);
    mcu_bus_model_i.xfer(BASE + 16'h0080, 1);
    chk({display_chip_select_n_o, display_cmd_param_in_sel_o}, 2'b01);
    mcu_bus_model_i.idle();
    mcu_bus_model_i.xfer(BASE + 16'h0081, 0);
    chk({display_chip_select_n_o, display_param_out_sel_o}, 2'b01);
    mcu_bus_model_i.idle();
    for (int r = 0; r < 8; r++) begin
      {clock_periodic_pulse_i, pulse_route_i} = r[2:0];
      w(4);
      chk({ext_irq0_n_o, ext_irq1_n_o, timer0_count_in_o, timer1_count_in_o}, {r[1:0] != 0 || r[2],
        r[1:0] != 1 || r[2], r[1:0] == 2 && r[2], r[1:0] == 3 && r[2]});
    end
    bump(1);
    chk(contrast_level_o, 6'h01);
    bump(62);
    chk(contrast_level_o, 6'h3F);
    bump(1);
    chk(contrast_level_o, 6'h00);
    for (int b = 0; b < 2; b++) begin
      buzzer_ctl_i = b[0];
      w(4);
      chk(buzzer_on_o, !b[0]);
    end
    {mcu_kbd_clk_drive_i, mcu_kbd_data_drive_i, kb_clk, kb_data} = 4'b0110;
    w(7);
    chk({kbd_clk_oe_n_o, kbd_data_oe_n_o, kbd_irq_o, mcu_kbd_clk_o, mcu_kbd_data_o, kbd_clk_o, kbd_data_o}, 7'h20);
    {mcu_kbd_clk_drive_i, mcu_kbd_data_drive_i, kb_clk, kb_data} = 4'b1011;
    w(7);
    chk({kbd_clk_oe_n_o, kbd_data_oe_n_o, kbd_irq_o, mcu_kbd_clk_o, mcu_kbd_data_o, kbd_clk_o, kbd_data_o}, 7'h58);
    {touch_cols_i, touch_rows_i} = {6'h2A, 10'h2C5};
    w(4);
    chk({touch_port5_o, touch_port4_o, touch_irq_o}, {6'h2A, 10'h2C5, 1'b1});
    touch_rows_i = 0;
    w(4);
    chk(touch_irq_o, 0);
    end_sim();
  end
endmodule
